//--- rtl/eep_i2c_target.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Two-entry buffer
module eep_buf2 #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] ent [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PW-1:0] wp_inc = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
  wire [PW-1:0] rp_inc = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;

  assign in_ready = (cnt_r != (PW + 1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = ent[rp_r];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_inc;
      if (pop)
        rp_r <= rp_inc;
      cnt_r <= cnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      ent[wp_r] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Serial memory target
module eep_i2c_target #(
  // Device type code; value is arbitrary
  parameter logic [3:0] TYPE_CODE = 4'h6
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Serial link
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Straps and protection
  input wire logic chip_select_strap_low,
  input wire logic chip_select_strap_high,
  input wire logic write_protect_input,
  // Status
  output logic prog_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: sample data, flag each rising edge
  logic lnk_bit_r;
  logic lnk_tog_r;

  always_ff @(posedge scl_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lnk_bit_r <= 1'b1;
      lnk_tog_r <= 1'b0;
    end
    else
    begin
      lnk_bit_r <= sda_i;
      lnk_tog_r <= ~lnk_tog_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system domain
  logic [6:0] sy1_r;
  logic [6:0] sy2_r;
  logic scl_d_r;
  logic sda_d_r;
  logic tog_d_r;
  wire [6:0] sy_in = {scl_clk, sda_i, lnk_bit_r, lnk_tog_r,
                      chip_select_strap_low, chip_select_strap_high,
                      write_protect_input};

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sy1_r <= 7'h60;
      sy2_r <= 7'h60;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      tog_d_r <= 1'b0;
    end
    else
    begin
      sy1_r <= sy_in;
      sy2_r <= sy1_r;
      scl_d_r <= sy2_r[6];
      sda_d_r <= sy2_r[5];
      tog_d_r <= sy2_r[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded events
  wire scl_s = sy2_r[6];
  wire sda_s = sy2_r[5];
  wire bit_s = sy2_r[4];
  wire tog_s = sy2_r[3];
  wire strap_lo = sy2_r[2];
  wire strap_hi = sy2_r[1];
  wire wp_s = sy2_r[0];

  eep_pkg::eep_state_t phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] tx_byte_r;
  logic [16:0] addr_r;
  logic [8:0] pg_base_r;
  logic [7:0] idx_r;
  logic ack_ok_r;
  logic wr_pend_r;
  logic [7:0] arr_mem [eep_pkg::ARRAY_DEPTH];
  logic [7:0] pg_data [eep_pkg::PAGE_BYTES];
  logic [eep_pkg::PAGE_BYTES-1:0] pg_vld_r;

  wire rise_ev = tog_s ^ tog_d_r;
  wire fall_ev = !scl_s && scl_d_r;
  wire start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s;
  wire in_prog = (phase_r == eep_pkg::PH_PROG);
  wire [7:0] rx_byte = {rx_sh_r[6:0], bit_s};
  wire byte_done = rise_ev && (bit_cnt_r == eep_pkg::BIT_LAST);
  wire ack_rise = rise_ev && (bit_cnt_r == eep_pkg::BIT_ACK);
  wire sel_match = (rx_byte[7:eep_pkg::SEL_TYPE_LSB] == TYPE_CODE)
                && (rx_byte[eep_pkg::SEL_STRAP_HI] == strap_hi)
                && (rx_byte[eep_pkg::SEL_STRAP_LO] == strap_lo);
  wire [16:0] rd_addr = {rx_byte[eep_pkg::SEL_ADDR16], addr_r[15:0]};
  wire [16:0] addr_inc = addr_r + 17'h0_0001;
  wire [7:0] page_inc = addr_r[7:0] + 8'h01;
  wire [2:0] tx_sel = ~bit_cnt_r[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // Write data buffer and page collection
  logic buf_in_ready;
  logic buf_out_valid;
  logic [15:0] buf_out_data;
  logic walk_r;
  wire push_ok = (phase_r == eep_pkg::PH_WDATA) && byte_done && !wp_s
              && buf_in_ready;
  wire drain = buf_out_valid && !walk_r;
  wire mem_we = walk_r && pg_vld_r[idx_r];
  wire walk_go = in_prog && !buf_out_valid && !walk_r;

  eep_buf2 #(.W(16), .DEPTH(2)) u_buf (
    .clk(clk_sys),
    .rstn(rstn),
    .in_valid(push_ok),
    .in_ready(buf_in_ready),
    .in_data({addr_r[7:0], rx_byte}),
    .out_valid(buf_out_valid),
    .out_ready(!walk_r),
    .out_data(buf_out_data)
  );

  always_ff @(posedge clk_sys)
  begin
    if (drain)
      pg_data[buf_out_data[15:8]] <= buf_out_data[7:0];
    if (mem_we)
      arr_mem[{pg_base_r, idx_r}] <= pg_data[idx_r];
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      pg_vld_r <= '0;
    else
    begin
      if (walk_r)
        pg_vld_r[idx_r] <= 1'b0;
      if (drain)
        pg_vld_r[buf_out_data[15:8]] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_r <= eep_pkg::PH_IDLE;
      bit_cnt_r <= eep_pkg::BIT_FIRST;
      rx_sh_r <= eep_pkg::RST_BYTE;
      tx_byte_r <= eep_pkg::RST_BYTE;
      addr_r <= eep_pkg::RST_ADDR;
      pg_base_r <= eep_pkg::RST_PAGE;
      idx_r <= eep_pkg::RST_BYTE;
      ack_ok_r <= 1'b0;
      wr_pend_r <= 1'b0;
      walk_r <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (in_prog)
    begin
      // Bus ignored while programming
      sda_oe_n <= 1'b1;
      if (walk_go)
        walk_r <= 1'b1;
      if (walk_r)
        idx_r <= idx_r + 8'h01;
      if (walk_r && idx_r == eep_pkg::LAST_OFFSET)
      begin
        walk_r <= 1'b0;
        phase_r <= eep_pkg::PH_IDLE;
      end
    end
    else if (start_ev)
    begin
      phase_r <= eep_pkg::PH_DEV;
      bit_cnt_r <= eep_pkg::BIT_FIRST;
      ack_ok_r <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (stop_ev)
    begin
      phase_r <= wr_pend_r ? eep_pkg::PH_PROG
                           : eep_pkg::PH_IDLE;
      wr_pend_r <= 1'b0;
      bit_cnt_r <= eep_pkg::BIT_FIRST;
      ack_ok_r <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      if (rise_ev)
      begin
        if (bit_cnt_r != eep_pkg::BIT_ACK)
          rx_sh_r <= rx_byte;
        bit_cnt_r <= (bit_cnt_r == eep_pkg::BIT_ACK) ? eep_pkg::BIT_FIRST
                                                     : bit_cnt_r + 4'h1;
      end
      if (byte_done)
      begin
        ack_ok_r <= 1'b0;
        case (phase_r)
          eep_pkg::PH_DEV:
          begin
            if (!sel_match)
              phase_r <= eep_pkg::PH_WAIT;
            else if (rx_byte[eep_pkg::SEL_RW])
            begin
              ack_ok_r <= 1'b1;
              addr_r <= rd_addr;
              tx_byte_r <= arr_mem[rd_addr];
              phase_r <= eep_pkg::PH_RDATA;
            end
            else
            begin
              ack_ok_r <= 1'b1;
              addr_r[16] <= rx_byte[eep_pkg::SEL_ADDR16];
              phase_r <= eep_pkg::PH_ADRH;
            end
          end
          eep_pkg::PH_ADRH:
          begin
            ack_ok_r <= 1'b1;
            addr_r[15:8] <= rx_byte;
            phase_r <= eep_pkg::PH_ADRL;
          end
          eep_pkg::PH_ADRL:
          begin
            ack_ok_r <= 1'b1;
            addr_r[7:0] <= rx_byte;
            pg_base_r <= addr_r[16:8];
            phase_r <= eep_pkg::PH_WDATA;
          end
          eep_pkg::PH_WDATA:
          begin
            if (wp_s)
              phase_r <= eep_pkg::PH_WAIT;
            else if (buf_in_ready)
            begin
              ack_ok_r <= 1'b1;
              wr_pend_r <= 1'b1;
              addr_r[7:0] <= page_inc;
            end
          end
          default:
          begin
            ack_ok_r <= 1'b0;
          end
        endcase
      end
      // Ack bit of the read select is ours, not the master's
      if (ack_rise && phase_r == eep_pkg::PH_RDATA && !ack_ok_r)
      begin
        if (!bit_s)
        begin
          addr_r <= addr_inc;
          tx_byte_r <= arr_mem[addr_inc];
        end
        else
          phase_r <= eep_pkg::PH_WAIT;
      end
      if (fall_ev)
      begin
        if (bit_cnt_r == eep_pkg::BIT_ACK)
          sda_oe_n <= !ack_ok_r;
        else if (phase_r == eep_pkg::PH_RDATA)
          sda_oe_n <= tx_byte_r[tx_sel];
        else
          sda_oe_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sda_o <= 1'b0;
      prog_busy <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
      prog_busy <= in_prog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_wr_byte;
    (phase_r == eep_pkg::PH_WDATA) && byte_done && !start_ev && !stop_ev;
  endsequence

  sequence s_rd_ack;
    (phase_r == eep_pkg::PH_RDATA) && ack_rise && !ack_ok_r && !bit_s
      && !start_ev && !stop_ev;
  endsequence

  chk_wp_refuse: assert property (
    s_wr_byte ##0 wp_s |=> (phase_r == eep_pkg::PH_WAIT) && !ack_ok_r)
    else $error("Protected data byte was acknowledged");

  chk_prog_only: assert property (
    mem_we |-> in_prog && prog_busy)
    else $error("Array written outside programming cycle");

  chk_stop_launch: assert property (
    stop_ev && wr_pend_r && !in_prog |=> in_prog ##1 prog_busy)
    else $error("Stop after write did not start programming");

  chk_page_wrap: assert property (
    s_wr_byte ##0 push_ok
      |=> addr_r[16:8] == $past(addr_r[16:8])
        && addr_r[7:0] == $past(addr_r[7:0]) + 8'h01)
    else $error("Write address left its page");

  chk_ack_drive: assert property (
    fall_ev && bit_cnt_r == eep_pkg::BIT_ACK && ack_ok_r && !in_prog
      && !start_ev && !stop_ev |=> !sda_oe_n)
    else $error("Acknowledge not driven");

  chk_seq_read: assert property (
    s_rd_ack |=> addr_r == $past(addr_r) + 17'h0_0001
      && phase_r == eep_pkg::PH_RDATA)
    else $error("Sequential read did not advance");

  chk_sel_nomatch: assert property (
    (phase_r == eep_pkg::PH_DEV) && byte_done && !sel_match && !start_ev
      && !stop_ev |=> (phase_r == eep_pkg::PH_WAIT) ##1 !ack_ok_r)
    else $error("Unmatched select was taken");

  chk_rx_sample: assert property (
    rise_ev && bit_cnt_r < eep_pkg::BIT_ACK && !in_prog && !start_ev
      && !stop_ev |=> rx_sh_r[0] == $past(bit_s))
    else $error("Data bit not sampled on rising edge");

  chk_stop_release: assert property (
    stop_ev && !in_prog |=> sda_oe_n [*2])
    else $error("Data line held after Stop");

endmodule

`default_nettype wire

//--- rtl/eep_pkg.sv
package eep_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Array organisation
  localparam int ARRAY_DEPTH = 131072;
  localparam int ADDR_W = 17;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Select byte field positions
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_STRAP_HI = 3;
  localparam int SEL_STRAP_LO = 2;
  localparam int SEL_ADDR16 = 1;
  localparam int SEL_RW = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Bit counter values
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and last page offset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [16:0] RST_ADDR = 17'h0_0000;
  localparam logic [7:0] LAST_OFFSET = 8'hFF;
  localparam logic [8:0] RST_PAGE = 9'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_MIN_PERIOD_NS = 1000;
  localparam int SCL_MIN_CYC = SCL_MIN_PERIOD_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction states
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_DEV   = 3'b001,
    PH_ADRH  = 3'b010,
    PH_ADRL  = 3'b011,
    PH_WDATA = 3'b100,
    PH_RDATA = 3'b101,
    PH_WAIT  = 3'b110,
    PH_PROG  = 3'b111
  } eep_state_t;

endpackage

//--- dv/eep_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Bus master model; a released SDA goes to the pull-up level
module eep_i2c_master (
  // Serial link
  output logic scl,
  output logic sda,
  input wire logic sda_line
);
  localparam int Q = 250;

  // SCL stands high between frames
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Start or repeated start, SCL left low
  task automatic start();
    sda = 1'b1;
    #Q scl = 1'b1;
    #Q sda = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sda = 1'b0;
    #Q scl = 1'b1;
    #Q sda = 1'b1;
    #Q;
  endtask

  // SDA moves only while SCL is low
  task automatic bit_xfer(input logic b, output logic v);
    sda = b;
    #Q scl = 1'b1;
    #Q v = sda_line;
    #Q scl = 0;
    #Q;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(d[i], ack_n);
    end
    bit_xfer(1'b1, ack_n);
  endtask

  // Acknowledge unless this is the final byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic v;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(last, v);
  endtask
endmodule

`default_nettype wire

//--- dv/i2c_eeprom_slave_port_tb.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module i2c_eeprom_slave_port_tb;
  // Device type code; value is arbitrary
  localparam logic [3:0] TC = 4'h9;
  localparam logic SHI = 1'b1;
  localparam logic SLO = 1'b0;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic strap_hi = SHI;
  logic strap_lo = SLO;
  logic wp = 1'b0;
  logic scl;
  logic m_sda;
  logic sda_o;
  logic sda_oe_n;
  logic prog_busy;
  wire sda_wire = m_sda & (sda_oe_n | sda_o);
  int fails = 0;
  int cmp_count = 0;

  always #4 clk_sys = ~clk_sys;

  eep_i2c_master mst (.scl(scl), .sda(m_sda), .sda_line(sda_wire));

  eep_i2c_target #(.TYPE_CODE(TC)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .scl_clk(scl), .sda_i(sda_wire),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .chip_select_strap_low(strap_lo), .chip_select_strap_high(strap_hi),
    .write_protect_input(wp), .prog_busy(prog_busy));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] sel(input logic adr_top, input logic rw);
    return {TC, SHI, SLO, adr_top, rw};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Start, write select, both address bytes
  task automatic head(input logic [16:0] a);
    logic ak;
    mst.start();
    mst.wr_byte(sel(a[16], 1'b0), ak);
    chk(8'(ak), 8'h00);
    mst.wr_byte(a[15:8], ak);
    chk(8'(ak), 8'h00);
    mst.wr_byte(a[7:0], ak);
    chk(8'(ak), 8'h00);
  endtask

  task automatic rd_at(input logic [16:0] a, input logic [7:0] e0,
                       input logic [7:0] e1, input logic two);
    logic ak;
    logic [7:0] d;
    head(a);
    mst.start();
    mst.wr_byte(sel(a[16], 1'b1), ak);
    chk(8'(ak), 8'h00);
    mst.rd_byte(!two, d);
    chk(d, e0);
    if (two)
    begin
      mst.rd_byte(1'b1, d);
      chk(d, e1);
    end
    mst.stop();
  endtask

  // Busy must rise after Stop, then end; probe tries a select meanwhile
  task automatic wait_prog(input logic probe);
    int n;
    logic ak;
    n = 0;
    while (prog_busy !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(8'(prog_busy), 8'h01);
    if (probe)
    begin
      mst.start();
      mst.wr_byte(sel(1'b0, 1'b0), ak);
      chk(8'(ak), 8'h01);
      mst.stop();
    end
    while (prog_busy !== 1'b0 && n < 600)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk(8'(prog_busy), 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    @(negedge clk_sys);
    chk(8'(sda_oe_n), 8'h01);
    chk(8'(sda_o), 8'h00);
    chk(8'(prog_busy), 8'h00);
  endtask

  task automatic s_byte();
    logic ak;
    head(17'h1_2345);
    mst.wr_byte(8'hA5, ak);
    chk(8'(ak), 8'h00);
    mst.stop();
    wait_prog(1'b1);
    rd_at(17'h1_2345, 8'hA5, 8'h00, 1'b0);
  endtask

  task automatic s_page();
    logic ak;
    logic [7:0] dat [3] = '{8'h11, 8'h22, 8'h33};
    head(17'h0_00FE);
    foreach (dat[i])
    begin
      mst.wr_byte(dat[i], ak);
      chk(8'(ak), 8'h00);
    end
    mst.stop();
    wait_prog(1'b0);
    rd_at(17'h0_00FE, 8'h11, 8'h22, 1'b1);
    rd_at(17'h0_0000, 8'h33, 8'h00, 1'b0);
  endtask

  task automatic s_sel();
    logic ak;
    logic [7:0] bad [3] = '{{TC ^ 4'h1, SHI, SLO, 2'b00},
                            {TC, ~SHI, SLO, 2'b00}, {TC, SHI, ~SLO, 2'b00}};
    foreach (bad[i])
    begin
      mst.start();
      mst.wr_byte(bad[i], ak);
      chk(8'(ak), 8'h01);
      mst.stop();
    end
  endtask

  task automatic s_wp();
    logic ak;
    @(posedge clk_sys);
    wp <= 1'b1;
    repeat (5) @(posedge clk_sys);
    head(17'h0_00FE);
    mst.wr_byte(8'h5A, ak);
    chk(8'(ak), 8'h01);
    mst.stop();
    repeat (50) @(negedge clk_sys);
    chk(8'(prog_busy), 8'h00);
    @(posedge clk_sys);
    wp <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rd_at(17'h0_00FE, 8'h11, 8'h00, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (10) @(posedge clk_sys);
    s_reset();
    s_byte();
    s_page();
    s_sel();
    s_wp();
    wrap_up();
  end

  // Run needs about 400 us; this allows ample margin
  initial
  begin
    #700_000;
    fails++;
    wrap_up();
  end
endmodule

`default_nettype wire
